// >>> logic/hlt_pkg.sv
// Package: register map, field layout and carrier types for line timing
package hlt_pkg;

	localparam int          ADDR_W     = 16;
	localparam logic [15:0] TIMING1_ADDR = 16'h8330;
	localparam logic [15:0] TIMING2_ADDR = 16'h8334;

	// Field positions shared by both timing registers
	localparam int HI_MSB  = 26;
	localparam int HI_LSB  = 19;
	localparam int HIR_MSB = 18;
	localparam int HIR_LSB = 16;
	localparam int LO_MSB  = 10;
	localparam int LO_LSB  = 3;
	localparam int LOR_MSB = 2;
	localparam int LOR_LSB = 0;

	// Pixels per character clock, as the last pixel index
	localparam logic [2:0] PIX_LAST = 3'h7;
	localparam logic [7:0] CHAR_ZERO = 8'h00;
	localparam logic [8:0] POS_STEP  = 9'h001;
	localparam logic [4:0] RSV_ZERO  = 5'h00;

	// One timing register: upper and lower count fields with low bits
	typedef struct packed {
		logic [7:0] hi;
		logic [2:0] hi_rsv;
		logic [7:0] lo;
		logic [2:0] lo_rsv;
	} hlt_reg_s;

	// Timing outputs that travel together toward the display paths
	typedef struct packed {
		logic       hblank;
		logic       active_de;
		logic       line_adv;
		logic [7:0] hcount;
	} hlt_timing_s;

endpackage : hlt_pkg

// >>> logic/hlt_line_timing.sv
// Horizontal line timing generator with its APB timing registers
// Notes on behaviour
// [RL1] The line length is taken from bits 26:19 of the first register as character clocks minus one.
// [RL2] Software must program the total larger than the active width.
// [RL3] When the total is written in pixels the low bits 18:16 play no part in timing.
// [RL4] Software keeps the total fixed for flat panel use in any mode.
// [RL5] The active width is bits 10:3 as character clocks minus one, and bits 2:0 play no part.
// [RL6] Software shifts blank and sync positions by the centering offset to centre a narrow image.
// [RL7] CRT and panel share one line total and one active width.
// [RL8] Blanking ends at the count in bits 26:19 of the second register plus one.
// [RL9] When the blank end is written in pixels the low bits 18:16 play no part.
// [RL10] Bits 18:16 and 2:0 of both registers are stored and read back but steer nothing.
// [RL11] Timing advances in character clocks of eight pixels.
// [RL12] Software must allow at least four character clocks of blanking per line.
// [RL13] Blanking begins at the count in bits 10:3 of the second register plus one.
// [RL14] The vertical counter is advanced by the line event even with only a panel attached.
// [RL15] The character counter returns to zero after reaching the total, ending the line.
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps

module hlt_line_timing (
	// Clock, reset, enable
	input  wire logic                      mclk,
	input  wire logic                      sys_rst,
	input  wire logic                      ce,
	// APB slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [hlt_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	output logic                           pready,
	output logic [31:0]                    prdata,
	output logic                           pslverr,
	// Timing outputs shared by CRT and panel paths
	output hlt_pkg::hlt_timing_s           timing
);

	hlt_pkg::hlt_reg_s line_total_active_timing;
	hlt_pkg::hlt_reg_s line_blank_timing;
	logic [2:0]        pix;
	logic [7:0]        next_hcount;
	logic              char_end;
	logic              line_end;
	logic              hit1;
	logic              hit2;
	logic              setup_ph;
	logic              access_ph;
	logic [8:0]        blank_on_at;
	logic [8:0]        blank_off_at;
	logic [8:0]        next_pos;

	assign hit1      = paddr == hlt_pkg::TIMING1_ADDR;
	assign hit2      = paddr == hlt_pkg::TIMING2_ADDR;
	assign setup_ph  = psel && !penable && !pready;
	assign access_ph = psel && penable && pready;

	// Answer in the first cycle of the access phase, right after setup; ce low stalls the bus too
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (ce) begin
			pready  <= setup_ph;
			if (setup_ph) begin
				pslverr <= !(hit1 || hit2);
				if (pwrite || !(hit1 || hit2))
					prdata <= 32'h00000000;
				else if (hit1)
					prdata <= {hlt_pkg::RSV_ZERO,
						line_total_active_timing[21:11],
						hlt_pkg::RSV_ZERO,
						line_total_active_timing[10:0]};
				else
					prdata <= {hlt_pkg::RSV_ZERO,
						line_blank_timing[21:11],
						hlt_pkg::RSV_ZERO,
						line_blank_timing[10:0]};
			end
		end
	end

	// Low bits are kept for read back only [RL10]
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			line_total_active_timing <= '0;
			line_blank_timing        <= '0;
		end else if (ce && access_ph && pwrite) begin
			if (hit1) begin
				line_total_active_timing.hi     <=
					pwdata[hlt_pkg::HI_MSB:hlt_pkg::HI_LSB];   // [RL1]
				line_total_active_timing.hi_rsv <=
					pwdata[hlt_pkg::HIR_MSB:hlt_pkg::HIR_LSB]; // [RL10]
				line_total_active_timing.lo     <=
					pwdata[hlt_pkg::LO_MSB:hlt_pkg::LO_LSB];   // [RL5]
				line_total_active_timing.lo_rsv <=
					pwdata[hlt_pkg::LOR_MSB:hlt_pkg::LOR_LSB]; // [RL10]
			end
			if (hit2) begin
				line_blank_timing.hi     <=
					pwdata[hlt_pkg::HI_MSB:hlt_pkg::HI_LSB];   // [RL8]
				line_blank_timing.hi_rsv <=
					pwdata[hlt_pkg::HIR_MSB:hlt_pkg::HIR_LSB]; // [RL10]
				line_blank_timing.lo     <=
					pwdata[hlt_pkg::LO_MSB:hlt_pkg::LO_LSB];   // [RL13]
				line_blank_timing.lo_rsv <=
					pwdata[hlt_pkg::LOR_MSB:hlt_pkg::LOR_LSB]; // [RL10]
			end
		end
	end

	// Only the character fields reach the counters [RL3] [RL9]
	assign char_end     = pix == hlt_pkg::PIX_LAST;           // [RL11]
	assign line_end     = char_end &&
		timing.hcount == line_total_active_timing.hi;     // [RL1]
	assign next_hcount  = line_end ? hlt_pkg::CHAR_ZERO
		: 8'(timing.hcount + 8'h01);                      // [RL15]
	assign next_pos     = {1'b0, next_hcount};
	assign blank_on_at  = {1'b0, line_blank_timing.lo} + hlt_pkg::POS_STEP;
	assign blank_off_at = {1'b0, line_blank_timing.hi} + hlt_pkg::POS_STEP;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			pix <= 3'h0;
		else if (ce)
			pix <= 3'(pix + 3'h1);
	end

	// One counter and one active compare serve both displays [RL7]
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			timing.hcount    <= hlt_pkg::CHAR_ZERO;
			timing.active_de <= 1'b0;
		end else if (ce && char_end) begin
			timing.hcount    <= next_hcount;
			timing.active_de <=
				next_hcount <= line_total_active_timing.lo;   // [RL5] [RL7]
		end
	end

	// Start wins when start and end coincide, so a bad setting stays blanked
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			timing.hblank <= 1'b0;
		else if (ce && char_end) begin
			if (next_pos == blank_on_at)
				timing.hblank <= 1'b1;                         // [RL13]
			else if (next_pos == blank_off_at)
				timing.hblank <= 1'b0;                         // [RL8]
		end
	end

	// Line event drives the vertical counter for CRT and panel alike
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			timing.line_adv <= 1'b0;
		else if (ce)
			timing.line_adv <= line_end;                       // [RL14]
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence apb_setup_s;
		ce && setup_ph;
	endsequence

	sequence line_last_s;
		ce && line_end;
	endsequence

	line_wrap_a: assert property (line_last_s |=> timing.hcount == 8'h00
		&& timing.line_adv) // [RL15]
		else $error("counter did not wrap at line total");

	total_field_a: assert property (ce && char_end && !line_end |=>
		timing.hcount == 8'($past(timing.hcount) + 8'h01)) // [RL1]
		else $error("counter did not step or wrapped early");

	char_hold_a: assert property (ce && !char_end |=>
		$stable(timing.hcount)) // [RL11]
		else $error("counter moved inside a character clock");

	blank_on_a: assert property (ce && char_end &&
		next_pos == blank_on_at |=> timing.hblank) // [RL13]
		else $error("blanking did not start");

	blank_off_a: assert property (ce && char_end &&
		next_pos == blank_off_at && next_pos != blank_on_at
		|=> !timing.hblank) // [RL8]
		else $error("blanking did not end");

	// Judged at the boundary, so a mid-line write cannot trip it
	active_width_a: assert property (ce && char_end &&
		next_hcount > line_total_active_timing.lo |=> !timing.active_de) // [RL5]
		else $error("display enable beyond active width");

	active_on_a: assert property (ce && char_end &&
		next_hcount <= line_total_active_timing.lo |=> timing.active_de) // [RL5]
		else $error("display enable missing inside active width");

	line_pulse_a: assert property (line_last_s ##1 ce |->
		timing.line_adv ##1 !timing.line_adv) // [RL14]
		else $error("line event is not a single pulse");

	rsvd_keep_a: assert property (ce && access_ph && pwrite && hit1 |=>
		line_total_active_timing.hi_rsv == $past(pwdata[18:16])
		&& line_total_active_timing.lo_rsv == $past(pwdata[2:0])) // [RL10]
		else $error("low bits not stored");

	apb_answer_a: assert property (apb_setup_s |=> pready ##1 !pready)
		else $error("slave answer timing wrong");

	blank_rsv_a: assert property (ce && access_ph && pwrite && hit2 |=>
		line_blank_timing.hi_rsv == $past(pwdata[18:16])
		&& line_blank_timing.lo_rsv == $past(pwdata[2:0])) // [RL10]
		else $error("low bits of blank register not stored");

	unmapped_err_a: assert property (apb_setup_s && !(hit1 || hit2) |=>
		pslverr && prdata == 32'h00000000)
		else $error("unmapped access not refused");

	// Enable low must hold the timing outputs and both timing registers, pready included
	ce_freeze_a: assert property (!ce |=> $stable(timing) && $stable(pready)
		&& $stable(line_total_active_timing)
		&& $stable(line_blank_timing))
		else $error("state moved while enable was low");

endmodule : hlt_line_timing

// >>> tb/hlt_display_model.sv
// Display model: measures the length of each scan line from line events
`timescale 1ns/100ps

module hlt_display_model (
	// Clock and timing from the generator
	input wire logic                 mclk,
	input wire hlt_pkg::hlt_timing_s timing,
	// Cycles between the last two line events
	output int                       line_len
);
	int cnt = 0;
	// One line event serves CRT and panel alike; no sync needed here
	always @(posedge mclk) begin
		cnt <= timing.line_adv ? 1 : cnt + 1;
		if (timing.line_adv)
			line_len <= cnt;
	end
endmodule : hlt_display_model

// >>> tb/hlt_line_timing_tb.sv
// Testbench for the horizontal line timing generator
`timescale 1ns/100ps

module hlt_line_timing_tb;
	logic mclk = 0, sys_rst, ce, psel, penable, pwrite, pslverr, pready, e;
	logic [15:0] paddr, ra [3];
	logic [31:0] pwdata, prdata, r, wd [3], rd [3];
	hlt_pkg::hlt_timing_s timing;
	int errors = 0, n_compared = 0, line_len, k;
	always #5 mclk = ~mclk;
	hlt_line_timing i_dut (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .timing(timing));
	hlt_display_model i_disp (.mclk(mclk), .timing(timing),
		.line_len(line_len));
	task give_verdict;
		if (errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Entered just after an edge; holds the request until pready is seen
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
		@(posedge mclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge mclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20) begin
			errors++;
			give_verdict();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb
	// Waits for the next line event, bounded
	task wait_line;
		int j;
		@(posedge mclk);
		for (j = 0; j < 300 && timing.line_adv !== 1'b1; j++)
			@(posedge mclk);
		if (j == 300) begin
			errors++;
			give_verdict();
		end
	endtask : wait_line
	initial begin
		ra = '{hlt_pkg::TIMING1_ADDR, hlt_pkg::TIMING2_ADDR,
			hlt_pkg::TIMING2_ADDR};
		wd = '{32'hFFFFFFFF, 32'h00000000, 32'hA5A5A5A5};
		rd = '{32'h07FF07FF, 32'h00000000, 32'h05A505A5};
		sys_rst = 1; ce = 1; psel = 0; penable = 0; pwrite = 0;
		paddr = 16'h0000; pwdata = 32'h00000000;
		repeat (6) @(posedge mclk);
		sys_rst <= 0;
		@(posedge mclk);
		for (k = 0; k < 3; k++) begin
			apb(1'b1, ra[k], wd[k]);
			apb(1'b0, ra[k], 32'h00000000);
			chk(r, rd[k]);
			chk({31'h0, e}, 32'h00000000);
		end
		// Unmapped word refuses with an error and reads zero
		apb(1'b1, 16'h8338, 32'hFFFFFFFF);
		chk({31'h0, e}, 32'h00000001);
		apb(1'b0, 16'h8338, 32'h00000000);
		chk(r, 32'h00000000);
		chk({31'h0, e}, 32'h00000001);
		// Total 9, active 3, blank 4..8; low bits set but must not matter
		apb(1'b1, hlt_pkg::TIMING1_ADDR, 32'h004F001F);
		apb(1'b1, hlt_pkg::TIMING2_ADDR, 32'h0047001F);
		wait_line();
		for (k = 0; k < 160; k++) begin
			@(posedge mclk);
			chk(timing.hblank, timing.hcount inside {[4:8]});
			chk(timing.active_de, timing.hcount <= 3);
			chk(timing.hcount > 9, 0);
		end
		chk(line_len, 80);
		// Centred image: blank window moved down by two, total unchanged
		apb(1'b1, hlt_pkg::TIMING1_ADDR, 32'h004F001F);
		apb(1'b1, hlt_pkg::TIMING2_ADDR, 32'h00300008);
		// Second line event: the first line may still hold the old window
		wait_line();
		wait_line();
		for (k = 0; k < 80; k++) begin
			@(posedge mclk);
			chk(timing.hblank, timing.hcount inside {[2:6]});
		end
		// Enable low freezes the counter and all timing outputs
		ce <= 1'b0;
		@(posedge mclk);
		r = {21'h0, timing};
		repeat (20) @(posedge mclk);
		chk({21'h0, timing}, r);
		ce <= 1'b1;
		// Reset in mid-line clears the counter and the registers
		sys_rst <= 1;
		repeat (2) @(posedge mclk);
		chk(timing.hcount, 0);
		chk({21'h0, timing}, 32'h00000000);
		chk({31'h0, pready}, 32'h00000000);
		sys_rst <= 0;
		@(posedge mclk);
		apb(1'b0, hlt_pkg::TIMING1_ADDR, 32'h00000000);
		chk(r, 32'h00000000);
		give_verdict();
	end
endmodule : hlt_line_timing_tb
